// file: common/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
	// Register byte addresses
	localparam logic [11:0] MISC_ADDR   = 12'h00C;
	localparam logic [11:0] STATUS_ADDR = 12'h010;
	// Control register field positions
	localparam int POR_BIT  = 7;
	localparam int RISE_BIT = 6;
	localparam int FALL_BIT = 5;
	localparam int IRQ_ENABLE_BIT_BIT = 4;
	localparam int SFA_BIT  = 3;
	localparam int SFB_BIT  = 2;
	localparam int SLOW_BIT = 1;
	localparam int WATCHDOG_BIT_BIT = 0;
	localparam logic [7:0] MISC_RST = 8'h90;
	// Status register field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_PEND_BIT  = 2;
	localparam int ST_SRC_LSB   = 3;
	// Stop-exit stabilisation choices, internal cycles
	localparam int STOP_DLY_SHORT = 16;
	localparam int STOP_DLY_LONG  = 4064;
	localparam int DLY_W          = 12;
	// Divider last count: oscillator ticks per bus cycle minus one
	localparam logic [4:0] DIV_FAST = 5'h01;
	localparam logic [4:0] DIV_SLOW = 5'h1F;
	// Vector pair base addresses
	localparam logic [15:0] VEC_EXT_IRQ = 16'h1FFA;
	localparam logic [15:0] VEC_RESET   = 16'h1FFE;
	// Internal reset drive length, clock cycles
	localparam int RST_DRIVE_CYC = 4;
	// Trigger option map: per code {level, active_high}
	localparam logic [7:0] TRIG_MAP_DEF = 8'b11_01_00_10;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOP,
		ST_DELAY,
		ST_WAIT
	} lpm_state_e;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_EXT,
		SRC_PERIPH,
		SRC_RESET
	} lpm_src_e;

	typedef struct packed {
		logic osc_en;
		logic timer_run;
		logic serial_run;
		logic adc_en;
		logic nvm_ro;
		logic pwm_hold;
		logic watchdog_bit_run;
	} lpm_periph_s;
endpackage
`default_nettype wire

// file: rtl/lpm_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Stop turns off oscillator, freezing timer, serial interface and converter.
// - Stop is left only by external interrupt or reset.
// - Entering stop clears the CPU interrupt mask bit.
// - Entering stop clears slow select so the exit count runs fast.
// - External interrupt wake vectors 1FFA/1FFB; reset wake vectors 1FFE/1FFF.
// - Leaving stop holds the CPU for 16 or 4064 internal cycles.
// - After the delay the CPU services the wake interrupt or reset vector.
// - Interrupt stacking happens only when the low-power state is left.
// - Registers and lines keep their state while stopped.
// - Stop resets watchdog, locks memory, halts serial, timer, converter, pulse outputs.
// - Wait halts CPU only; watchdog follows its build option.
// - Entering wait clears mask bit, interrupt enable bit untouched.
// - Wait ends on external, timer, serial interrupt or reset pin low.
// - Non-reset wait exit keeps state; reset exit returns reset state.
// - Slow select gives bus clock oscillator/32, otherwise oscillator/2.
// - Slow select cleared by external and power-on reset.
// - Control register at 000C holds the listed bits, slow select bit 1.
// - Two select bits pick the trigger; enable bit clear disables input.
// - Trigger select writes take effect only while mask bit is set.
// - Changing the trigger option clears a pending external interrupt.
// - Internal reset drives reset pin low open-drain.
module lpm_ctrl #(
	parameter int unsigned STOP_DLY_CYC = lpm_pkg::STOP_DLY_LONG,
	parameter bit          WATCHDOG_BIT_IN_WAIT = 1'b1,
	parameter logic [7:0]  TRIG_MAP     = lpm_pkg::TRIG_MAP_DEF
) (
	// Clock and power-on reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// CPU core
	input  wire logic         stop_req,
	input  wire logic         wait_req,
	input  wire logic         cpu_i_bit,
	input  wire logic         irq_ack,
	output logic              i_bit_clear,
	output logic              cpu_hold,
	output logic              stack_now,
	output logic              vector_valid,
	output logic [15:0]       vector_addr,
	output logic              irq_pending,
	// Wake sources
	input  wire logic         irq_pin,
	input  wire logic         timer_irq,
	input  wire logic         serial_irq,
	input  wire logic         watchdog_bit_reset,
	// Reset pin, open drain
	input  wire logic         rst_pin_in,
	output logic              rst_pin_out,
	output logic              rst_pin_oe_n,
	// Clocking and peripheral control
	output logic              bus_tick,
	output logic              watchdog_bit_clear,
	output var lpm_pkg::lpm_periph_s periph
);
	localparam logic [lpm_pkg::DLY_W-1:0] DLY_LOAD =
		lpm_pkg::DLY_W'(STOP_DLY_CYC - 1);
	localparam logic [2:0] RST_LOAD = 3'(lpm_pkg::RST_DRIVE_CYC - 1);

	logic                      srst;
	logic                      acc_done;
	logic                      wr_misc;
	logic [7:0]                misc_reg, misc_next;
	logic                      pend_reg, pend_next;
	logic                      irq_prev_reg;
	logic [1:0]                trig_code;
	logic [1:0]                trig_kind;
	logic                      trig_hit;
	lpm_pkg::lpm_state_e       state_reg, state_next;
	lpm_pkg::lpm_src_e         src_reg, src_next;
	logic [lpm_pkg::DLY_W-1:0] dly_reg, dly_next;
	logic [4:0]                pre_reg, pre_next;
	logic                      tick_reg, tick_next;
	logic                      iclr_next, wclr_next, stk_next, vv_next;
	logic                      iclr_reg, wclr_reg, stk_reg, vv_reg;
	logic [15:0]               vec_reg, vec_next;
	lpm_pkg::lpm_periph_s      per_reg, per_next;
	logic                      hold_reg;
	logic [31:0]               rd_reg, rd_next;
	logic                      rdy_reg, rdy_next, err_reg, err_next;
	logic [2:0]                rcnt_reg, rcnt_next;
	logic                      rdrv_reg, rdrv_next;

	// Reset pin is a synchronous level; low means external reset
	assign srst = !rst_pin_in;

	// APB: one wait state, writes land on the completing edge
	assign acc_done = psel && penable && rdy_reg;
	assign wr_misc  = acc_done && pwrite && pstrb[0] &&
		(paddr == lpm_pkg::MISC_ADDR);

	always_comb begin
		rdy_next = psel && penable && !rdy_reg;
		rd_next  = rd_reg;
		err_next = 1'b0;
		if (psel && penable && !rdy_reg) begin
			rd_next = 32'h0000_0000;
			case (paddr)
				lpm_pkg::MISC_ADDR:   rd_next[7:0] = misc_reg;
				lpm_pkg::STATUS_ADDR: begin
					rd_next[lpm_pkg::ST_STATE_LSB +: 2] = state_reg;
					rd_next[lpm_pkg::ST_PEND_BIT]       = pend_reg;
					rd_next[lpm_pkg::ST_SRC_LSB +: 2]   = src_reg;
				end
				default: err_next = 1'b1;
			endcase
			if (pwrite && paddr == lpm_pkg::STATUS_ADDR) begin
				err_next = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg  <= 32'h0000_0000;
			rdy_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			rd_reg  <= rd_next;
			rdy_reg <= rdy_next;
			err_reg <= err_next;
		end
	end

	// Trigger decode: per code {level, active_high}
	assign trig_code = {misc_reg[lpm_pkg::RISE_BIT], misc_reg[lpm_pkg::FALL_BIT]};
	assign trig_kind = TRIG_MAP[{trig_code, 1'b0} +: 2];
	always_comb begin
		if (trig_kind[1]) begin
			trig_hit = (irq_pin == trig_kind[0]);
		end else begin
			trig_hit = (irq_pin != irq_prev_reg) && (irq_pin == trig_kind[0]);
		end
	end

	// Control register and external interrupt pending flag
	always_comb begin
		misc_next = misc_reg;
		pend_next = pend_reg;
		if (wr_misc) begin
			if (cpu_i_bit) begin
				misc_next[lpm_pkg::RISE_BIT] = pwdata[lpm_pkg::RISE_BIT];
				misc_next[lpm_pkg::FALL_BIT] = pwdata[lpm_pkg::FALL_BIT];
			end
			misc_next[lpm_pkg::IRQ_ENABLE_BIT_BIT] = pwdata[lpm_pkg::IRQ_ENABLE_BIT_BIT];
			misc_next[lpm_pkg::SFA_BIT]  = pwdata[lpm_pkg::SFA_BIT];
			misc_next[lpm_pkg::SFB_BIT]  = pwdata[lpm_pkg::SFB_BIT];
			misc_next[lpm_pkg::SLOW_BIT] = pwdata[lpm_pkg::SLOW_BIT];
			misc_next[lpm_pkg::WATCHDOG_BIT_BIT] = pwdata[lpm_pkg::WATCHDOG_BIT_BIT];
			// Power-on flag can only be cleared
			misc_next[lpm_pkg::POR_BIT] = misc_reg[lpm_pkg::POR_BIT] &&
				pwdata[lpm_pkg::POR_BIT];
		end
		if (state_reg == lpm_pkg::ST_RUN && stop_req) begin
			misc_next[lpm_pkg::SLOW_BIT] = 1'b0;
		end
		// edge/level capture, ack loses to a new event
		if (irq_ack) begin
			pend_next = 1'b0;
		end
		if (trig_hit && misc_reg[lpm_pkg::IRQ_ENABLE_BIT_BIT]) begin
			pend_next = 1'b1;
		end else if (trig_kind[1]) begin
			pend_next = 1'b0;
		end
		if (misc_next[lpm_pkg::RISE_BIT] != misc_reg[lpm_pkg::RISE_BIT] ||
			misc_next[lpm_pkg::FALL_BIT] != misc_reg[lpm_pkg::FALL_BIT]) begin
			pend_next = 1'b0;
		end
		if (!misc_next[lpm_pkg::IRQ_ENABLE_BIT_BIT]) begin
			pend_next = 1'b0;
		end
		// external reset restores fields, keeps power-on flag
		if (srst) begin
			misc_next = {misc_reg[lpm_pkg::POR_BIT], lpm_pkg::MISC_RST[6:0]};
			pend_next = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_reg     <= lpm_pkg::MISC_RST;
			pend_reg     <= 1'b0;
			// Idle-high pin, so no false edge after reset
			irq_prev_reg <= 1'b1;
		end else begin
			misc_reg     <= misc_next;
			pend_reg     <= pend_next;
			irq_prev_reg <= irq_pin;
		end
	end

	// Bus clock divider; frozen with the oscillator in stop
	always_comb begin
		pre_next  = pre_reg;
		tick_next = 1'b0;
		if (state_reg != lpm_pkg::ST_STOP) begin
			if (pre_reg >= (misc_reg[lpm_pkg::SLOW_BIT] ?
				lpm_pkg::DIV_SLOW : lpm_pkg::DIV_FAST)) begin
				pre_next  = 5'h00;
				tick_next = 1'b1;
			end else begin
				pre_next = pre_reg + 5'h01;
			end
		end
		if (srst) begin
			pre_next  = 5'h00;
			tick_next = 1'b0;
		end
	end

	// Power-mode sequencer
	always_comb begin
		state_next = state_reg;
		src_next   = src_reg;
		dly_next   = dly_reg;
		iclr_next  = 1'b0;
		wclr_next  = 1'b0;
		stk_next   = 1'b0;
		vv_next    = 1'b0;
		vec_next   = vec_reg;
		case (state_reg)
			lpm_pkg::ST_RUN: begin
				if (stop_req) begin
					// mask bit cleared on stop entry
					state_next = lpm_pkg::ST_STOP;
					iclr_next  = 1'b1;
					wclr_next  = 1'b1;
					src_next   = lpm_pkg::SRC_NONE;
				end else if (wait_req) begin
					// mask bit cleared, enable bit kept
					state_next = lpm_pkg::ST_WAIT;
					iclr_next  = 1'b1;
					src_next   = lpm_pkg::SRC_NONE;
				end
			end
			lpm_pkg::ST_STOP: begin
				// only the external request leaves stop here
				if (pend_reg) begin
					state_next = lpm_pkg::ST_DELAY;
					src_next   = lpm_pkg::SRC_EXT;
					dly_next   = DLY_LOAD;
				end
			end
			lpm_pkg::ST_DELAY: begin
				if (tick_reg) begin
					if (dly_reg == '0) begin
						state_next = lpm_pkg::ST_RUN;
						vv_next    = 1'b1;
						// stacking only on the way out
						stk_next   = (src_reg == lpm_pkg::SRC_EXT);
						vec_next   = (src_reg == lpm_pkg::SRC_EXT) ?
							lpm_pkg::VEC_EXT_IRQ : lpm_pkg::VEC_RESET;
					end else begin
						dly_next = dly_reg - lpm_pkg::DLY_W'(1);
					end
				end
			end
			lpm_pkg::ST_WAIT: begin
				if (pend_reg || timer_irq || serial_irq) begin
					state_next = lpm_pkg::ST_RUN;
					stk_next   = 1'b1;
					src_next   = pend_reg ? lpm_pkg::SRC_EXT :
						lpm_pkg::SRC_PERIPH;
					vv_next    = pend_reg;
					vec_next   = lpm_pkg::VEC_EXT_IRQ;
				end
			end
			default: state_next = lpm_pkg::ST_RUN;
		endcase
		// reset exit goes through the reset delay and vector
		if (srst) begin
			state_next = lpm_pkg::ST_DELAY;
			src_next   = lpm_pkg::SRC_RESET;
			dly_next   = DLY_LOAD;
			iclr_next  = 1'b0;
			wclr_next  = 1'b0;
			stk_next   = 1'b0;
			vv_next    = 1'b0;
		end
	end

	always_comb begin
		per_next.osc_en     = (state_next != lpm_pkg::ST_STOP);
		per_next.timer_run  = (state_next != lpm_pkg::ST_STOP);
		per_next.serial_run = (state_next != lpm_pkg::ST_STOP);
		per_next.adc_en     = (state_next != lpm_pkg::ST_STOP);
		per_next.nvm_ro     = (state_next == lpm_pkg::ST_STOP);
		per_next.pwm_hold   = (state_next == lpm_pkg::ST_STOP);
		// watchdog in wait per build option
		per_next.watchdog_bit_run   = (state_next == lpm_pkg::ST_RUN) ||
			(state_next == lpm_pkg::ST_DELAY) ||
			(state_next == lpm_pkg::ST_WAIT && WATCHDOG_BIT_IN_WAIT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= lpm_pkg::ST_DELAY;
			src_reg   <= lpm_pkg::SRC_RESET;
			dly_reg   <= DLY_LOAD;
			pre_reg   <= 5'h00;
			tick_reg  <= 1'b0;
			iclr_reg  <= 1'b0;
			wclr_reg  <= 1'b0;
			stk_reg   <= 1'b0;
			vv_reg    <= 1'b0;
			vec_reg   <= lpm_pkg::VEC_RESET;
			per_reg   <= '0;
			hold_reg  <= 1'b1;
		end else begin
			state_reg <= state_next;
			src_reg   <= src_next;
			dly_reg   <= dly_next;
			pre_reg   <= pre_next;
			tick_reg  <= tick_next;
			iclr_reg  <= iclr_next;
			wclr_reg  <= wclr_next;
			stk_reg   <= stk_next;
			vv_reg    <= vv_next;
			vec_reg   <= vec_next;
			per_reg   <= per_next;
			hold_reg  <= (state_next != lpm_pkg::ST_RUN);
		end
	end

	// Internal reset stretcher; immune to its own echo on the pin
	always_comb begin
		rcnt_next = rcnt_reg;
		rdrv_next = rdrv_reg;
		if (watchdog_bit_reset) begin
			rdrv_next = 1'b1;
			rcnt_next = RST_LOAD;
		end else if (rdrv_reg) begin
			if (rcnt_reg == 3'h0) begin
				rdrv_next = 1'b0;
			end else begin
				rcnt_next = rcnt_reg - 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_reg <= 3'h0;
			rdrv_reg <= 1'b0;
		end else begin
			rcnt_reg <= rcnt_next;
			rdrv_reg <= rdrv_next;
		end
	end

	assign prdata       = rd_reg;
	assign pready       = rdy_reg;
	assign pslverr      = err_reg;
	assign i_bit_clear  = iclr_reg;
	assign cpu_hold     = hold_reg;
	assign stack_now    = stk_reg;
	assign vector_valid = vv_reg;
	assign vector_addr  = vec_reg;
	assign irq_pending  = pend_reg;
	assign rst_pin_out  = 1'b0;
	assign rst_pin_oe_n = !rdrv_reg;
	assign bus_tick     = tick_reg;
	assign watchdog_bit_clear   = wclr_reg;
	assign periph       = per_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stop_entry;
		state_reg == lpm_pkg::ST_RUN && stop_req && !srst;
	endsequence

	sequence s_delay_done;
		state_reg == lpm_pkg::ST_DELAY && tick_reg && dly_reg == '0 && !srst;
	endsequence

	chk_stop_osc_off: assert property (s_stop_entry |=>
		!periph.osc_en && periph.nvm_ro && cpu_hold)
		else $error("oscillator not off after stop");
	chk_stop_wake_only: assert property (
		state_reg == lpm_pkg::ST_STOP && !pend_reg && !srst |=>
		state_reg == lpm_pkg::ST_STOP)
		else $error("stop left without wake event");
	chk_stop_ibit_clr: assert property (s_stop_entry |=> i_bit_clear)
		else $error("mask clear missing on stop");
	chk_stop_slow_clr: assert property (s_stop_entry |=>
		!misc_reg[lpm_pkg::SLOW_BIT])
		else $error("slow select kept in stop");
	chk_delay_load: assert property (
		state_reg == lpm_pkg::ST_DELAY && $past(state_reg) != lpm_pkg::ST_DELAY
		|-> dly_reg == DLY_LOAD)
		else $error("stop exit delay wrong length");
	chk_wake_vector: assert property (s_delay_done |=>
		vector_valid && vector_addr == (($past(src_reg) == lpm_pkg::SRC_EXT) ?
		lpm_pkg::VEC_EXT_IRQ : lpm_pkg::VEC_RESET))
		else $error("wrong wake vector");
	chk_wait_wake: assert property (
		state_reg == lpm_pkg::ST_WAIT && (timer_irq || serial_irq) && !srst
		|=> !cpu_hold && stack_now)
		else $error("wait not left on interrupt");
	chk_trig_lock: assert property (wr_misc && !cpu_i_bit |=>
		$stable(trig_code))
		else $error("trigger changed with mask clear");
	chk_trig_flush: assert property ($changed(trig_code) |->
		!pend_reg)
		else $error("pending kept over trigger change");
	chk_rst_drive: assert property (watchdog_bit_reset |=>
		!rst_pin_oe_n [*4])
		else $error("reset pin not driven");
endmodule // lpm_ctrl
`default_nettype wire

// file: bench/lpm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_cpu_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench commands
	input  wire logic        cmd_stop,
	input  wire logic        cmd_wait,
	input  wire logic        cmd_mask,
	// Controller side
	input  wire logic        i_bit_clear,
	input  wire logic        vector_valid,
	input  wire logic [15:0] vector_addr,
	output logic             stop_req,
	output logic             wait_req,
	output logic             cpu_i_bit,
	output logic             irq_ack
);
	// Starts unmasked so ignored option writes can be tried first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_req  <= 1'b0;
			wait_req  <= 1'b0;
			cpu_i_bit <= 1'b0;
			irq_ack   <= 1'b0;
		end else begin
			stop_req  <= cmd_stop;
			wait_req  <= cmd_wait;
			irq_ack   <= vector_valid && vector_addr == lpm_pkg::VEC_EXT_IRQ;
			if (i_bit_clear) begin
				cpu_i_bit <= 1'b0;
			end else if (cmd_mask) begin
				cpu_i_bit <= 1'b1;
			end
		end
	end
endmodule // lpm_cpu_model
`default_nettype wire

// file: bench/low_power_mode_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control_bench;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err;
	logic        cmd_stop, cmd_wait, cmd_mask;
	logic        stop_req, wait_req, cpu_i_bit, irq_ack;
	logic        i_bit_clear, cpu_hold, stack_now, vector_valid;
	logic [15:0] vector_addr;
	logic        irq_pending, irq_pin, timer_irq, serial_irq, watchdog_bit_reset;
	logic        rst_pin_out, rst_pin_oe_n, bus_tick, watchdog_bit_clear;
	wire logic   rst_pin_in;
	lpm_pkg::lpm_periph_s periph;
	int          errors, checks, n, c;

	// Reset pin has a pull-up; only the open drain pulls it low
	assign rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;

	lpm_ctrl #(.STOP_DLY_CYC(16)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stop_req(stop_req), .wait_req(wait_req), .cpu_i_bit(cpu_i_bit),
		.irq_ack(irq_ack), .i_bit_clear(i_bit_clear), .cpu_hold(cpu_hold),
		.stack_now(stack_now), .vector_valid(vector_valid),
		.vector_addr(vector_addr), .irq_pending(irq_pending),
		.irq_pin(irq_pin), .timer_irq(timer_irq), .serial_irq(serial_irq),
		.watchdog_bit_reset(watchdog_bit_reset), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
		.bus_tick(bus_tick), .watchdog_bit_clear(watchdog_bit_clear), .periph(periph)
	);

	lpm_cpu_model u_cpu (
		.pclk(pclk), .presetn(presetn), .cmd_stop(cmd_stop),
		.cmd_wait(cmd_wait), .cmd_mask(cmd_mask), .i_bit_clear(i_bit_clear),
		.vector_valid(vector_valid), .vector_addr(vector_addr),
		.stop_req(stop_req), .wait_req(wait_req), .cpu_i_bit(cpu_i_bit),
		.irq_ack(irq_ack)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic final_report();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait for one of the controller's events
	task automatic wait_for(input int which);
		int k;
		logic hit;
		for (k = 1; k < 300; k++) begin
			@(posedge pclk);
			case (which)
				0: hit = i_bit_clear;
				1: hit = vector_valid;
				2: hit = !cpu_hold;
				3: hit = irq_pending;
				default: hit = !rst_pin_oe_n;
			endcase
			n = k;
			if (hit === 1'b1) return;
		end
		errors++;
		final_report();
	endtask

	task automatic count_ticks(input int exp);
		c = 0;
		repeat (64) begin
			@(posedge pclk);
			c += int'(bus_tick === 1'b1);
		end
		check("bus ticks", c, exp);
	endtask

	task automatic pulse(input int which);
		case (which)
			0: cmd_stop <= 1'b1;
			1: cmd_wait <= 1'b1;
			2: cmd_mask <= 1'b1;
			default: watchdog_bit_reset <= 1'b1;
		endcase
		@(posedge pclk);
		{cmd_stop, cmd_wait, cmd_mask, watchdog_bit_reset} <= 4'h0;
	endtask

	initial begin
		{errors, checks, n, c} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cmd_stop, cmd_wait, cmd_mask, timer_irq, watchdog_bit_reset} = '0;
		irq_pin = 1'b1;
		serial_irq = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("misc reset", rd, 32'h0000_0090);
		wait_for(1);
		check("reset vector", vector_addr, lpm_pkg::VEC_RESET);
		check("hold after delay", cpu_hold, 1'b0);
		// Trigger bits refused while unmasked
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'hF0);
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("misc unmasked", rd, 32'h0000_0090);
		pulse(2);
		irq_pin <= 1'b0;
		wait_for(3);
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'hD0);
		@(posedge pclk);
		check("pending", irq_pending, 1'b0);
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("misc masked", rd, 32'h0000_00D0);
		count_ticks(32);
		// Bus clock at oscillator/32 while slow, then stop entry
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'hD2);
		count_ticks(2);
		pulse(0);
		wait_for(0);
		check("stop periph", periph[6:1], 32'h0000_0003);
		check("watchdog clear", watchdog_bit_clear, 1'b1);
		@(posedge pclk);
		check("stop mask", cpu_i_bit, 1'b0);
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("stop slow", rd, 32'h0000_00D0);
		timer_irq <= 1'b1;
		repeat (8) @(posedge pclk);
		check("stop hold", cpu_hold, 1'b1);
		timer_irq <= 1'b0;
		irq_pin <= 1'b1;
		wait_for(1);
		check("irq vector", vector_addr, lpm_pkg::VEC_EXT_IRQ);
		check("stop stack", stack_now, 1'b1);
		check("wake delay", n >= 32 && n <= 44, 1'b1);
		pulse(1);
		wait_for(0);
		check("wait periph", periph, 32'h0000_0079);
		timer_irq <= 1'b1;
		wait_for(2);
		check("wait stack", stack_now, 1'b1);
		check("wait vector", vector_valid, 1'b0);
		timer_irq <= 1'b0;
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("wait misc", rd, 32'h0000_00D0);
		// Second wait, left by the serial interface
		pulse(1);
		wait_for(0);
		serial_irq <= 1'b1;
		wait_for(2);
		check("serial wake", stack_now, 1'b1);
		serial_irq <= 1'b0;
		apb(1'b0, lpm_pkg::STATUS_ADDR, 8'h00);
		check("status periph", rd, 32'h0000_0010);
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'h50);
		pulse(3);
		wait_for(4);
		c = 0;
		while (rst_pin_oe_n === 1'b0 && c < 20) begin
			@(posedge pclk);
			c++;
		end
		check("pin drive", c, 4);
		wait_for(1);
		check("pin vector", vector_addr, lpm_pkg::VEC_RESET);
		apb(1'b0, lpm_pkg::MISC_ADDR, 8'h00);
		check("misc pin reset", rd, 32'h0000_0010);
		apb(1'b1, lpm_pkg::STATUS_ADDR, 8'h00);
		check("status write", err, 1'b1);
		apb(1'b0, 12'h014, 8'h00);
		check("unmapped", err, 1'b1);
		// Falling edge, then high level, then input disabled
		pulse(2);
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'h30);
		irq_pin <= 1'b0;
		wait_for(3);
		check("fall edge", irq_pending, 1'b1);
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'h70);
		irq_pin <= 1'b1;
		wait_for(3);
		check("high level", irq_pending, 1'b1);
		apb(1'b1, lpm_pkg::MISC_ADDR, 8'h60);
		@(posedge pclk);
		check("enable off", irq_pending, 1'b0);
		final_report();
	end
endmodule // low_power_mode_control_bench
`default_nettype wire
